// file: rtl/ccr_clock_control.sv
// ccr_clock_control: register file, watchdog self-recovery and power-down
// sequencing of a clock generator. assumes pins arrive asynchronously and
// are sampled by clock; register port strobes are synchronous to clock.
`timescale 1ns/1ps
module ccr_clock_control #(
  parameter longint REF_CYCLES_PER_TICK = ccr_pkg::REF_CYCLES_PER_TICK,
  parameter longint RESUME_MAX_CYCLES = ccr_pkg::RESUME_MAX_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic [4:0] frequencySelectStraps,
  input wire logic hostFamilySelect,
  input wire logic cpuClockTrue,
  input wire logic cpuClockComp,
  input wire logic outputClockSample,
  input wire logic refClockSample,
  input wire logic powerDownN,
  input wire logic terminationPowerGoodN,
  output logic systemResetOutN,
  output logic [4:0] activeFrequencySelect,
  output logic [15:0] frequencyWord,
  output logic [6:0] fineTuneN,
  output logic [5:0] fineTuneR,
  output logic fineTuneSourceSelect,
  output logic [26:0] pllConstant,
  output logic spreadEnable,
  output logic spreadMode,
  output logic spreadTypeHi,
  output logic spreadTypeLo,
  output logic nonCpuHoldLow,
  output logic refHoldLow,
  output logic cpuHoldLow,
  output logic cpuTrueDriveHigh,
  output logic cpuCompOeN,
  output logic pllEnable,
  output logic oscillatorEnable,
  output logic serialInterfaceEnable,
  output logic powerGoodLatched
);
  // pin synchronisers
  logic [ccr_pkg::PIN_COUNT-1:0] pinRaw;
  logic [ccr_pkg::PIN_COUNT-1:0] pinLevel;
  logic [ccr_pkg::PIN_COUNT-1:0] pinRise;
  logic [ccr_pkg::PIN_COUNT-1:0] pinFall;
  logic [4:0] strapMeta;
  logic [4:0] strapStable;

  assign pinRaw = {hostFamilySelect, terminationPowerGoodN, powerDownN, refClockSample,
                   outputClockSample, cpuClockComp, cpuClockTrue};

  ccr_pin_sync #(.N(ccr_pkg::PIN_COUNT)) u_sync (
    .clock(clock),
    .rst(rst),
    .clockEnable(clockEnable),
    .pinIn(pinRaw),
    .level(pinLevel),
    .rise(pinRise),
    .fall(pinFall)
  );

  // register state
  logic [3:0] timeoutSel;
  logic wdResetEnable;
  logic wdRecoverPrevious;
  logic watchdogAlarmFlag;
  logic [4:0] strapFreq;
  logic [4:0] lastSwFreq;
  logic [4:0] prevSwFreq;
  logic strapCaptured;
  logic [2:0] strapWait;

  // register decode
  function automatic logic hitReg(input logic [7:0] addr, input logic [7:0] reg_off);
    hitReg = (addr == reg_off);
  endfunction

  wire busWrite = regWrite & serialInterfaceEnable;
  wire busRead = regRead & serialInterfaceEnable;
  wire wrSpread = busWrite & hitReg(regAddr, ccr_pkg::REG_SPREAD);
  wire wrSwFreq = busWrite & hitReg(regAddr, ccr_pkg::REG_SW_FREQ);
  wire wrFineN = busWrite & hitReg(regAddr, ccr_pkg::REG_FINE_N);
  wire wrFineR = busWrite & hitReg(regAddr, ccr_pkg::REG_FINE_R);
  wire wrWatchdog = busWrite & hitReg(regAddr, ccr_pkg::REG_WATCHDOG);
  wire wrFreqLo = busWrite & hitReg(regAddr, ccr_pkg::REG_FREQ_LO);
  wire wrFreqHi = busWrite & hitReg(regAddr, ccr_pkg::REG_FREQ_HI);
  wire [3:0] wrTimeout = regWriteData[ccr_pkg::WD_TIMEOUT_W-1:0];
  wire timeoutZeroWrite = wrWatchdog & (wrTimeout == ccr_pkg::WD_TIMEOUT_OFF);
  wire freqRequest = wrSwFreq | wrFreqLo | wrFreqHi;
  wire armWatchdog = freqRequest & (timeoutSel != ccr_pkg::WD_TIMEOUT_OFF);

  // read mux
  wire [7:0] spreadByte = {spreadEnable, spreadMode, spreadTypeHi, spreadTypeLo, 4'h0};
  wire [7:0] wdByte = {wdResetEnable, wdRecoverPrevious, 1'b0, watchdogAlarmFlag, timeoutSel};
  wire [7:0] fineRByte = {1'b0, fineTuneR, fineTuneSourceSelect};
  wire [7:0] readMux =
    hitReg(regAddr, ccr_pkg::REG_SPREAD) ? spreadByte :
    hitReg(regAddr, ccr_pkg::REG_SW_FREQ) ? {3'h0, lastSwFreq} :
    hitReg(regAddr, ccr_pkg::REG_FINE_N) ? {1'b0, fineTuneN} :
    hitReg(regAddr, ccr_pkg::REG_FINE_R) ? fineRByte :
    hitReg(regAddr, ccr_pkg::REG_WATCHDOG) ? wdByte :
    hitReg(regAddr, ccr_pkg::REG_FREQ_LO) ? frequencyWord[7:0] :
    hitReg(regAddr, ccr_pkg::REG_FREQ_HI) ? frequencyWord[15:8] : 8'h00;

  always_ff @(posedge clock)
  begin
    if (rst)
      regReadData <= 8'h00;
    else if (clockEnable)
      regReadData <= busRead ? readMux : 8'h00;
  end

  // control registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      {spreadEnable, spreadMode, spreadTypeHi, spreadTypeLo} <= ccr_pkg::SPREAD_RESET;
      fineTuneN <= ccr_pkg::FINE_N_RESET;
      fineTuneR <= ccr_pkg::FINE_R_RESET;
      fineTuneSourceSelect <= ccr_pkg::FINE_SRC_RESET;
      wdResetEnable <= ccr_pkg::WD_RST_EN_RESET;
      wdRecoverPrevious <= ccr_pkg::WD_SRC_RESET;
      timeoutSel <= ccr_pkg::WD_TIMEOUT_OFF;
      frequencyWord <= ccr_pkg::FREQ_WORD_RESET;
    end
    else if (clockEnable)
    begin
      if (wrSpread)
      begin
        spreadEnable <= regWriteData[ccr_pkg::SPREAD_EN_BIT];
        spreadMode <= regWriteData[ccr_pkg::SPREAD_MODE_BIT];
        spreadTypeHi <= regWriteData[ccr_pkg::SPREAD_HI_BIT];
        spreadTypeLo <= regWriteData[ccr_pkg::SPREAD_LO_BIT];
      end
      if (wrFineN)
        fineTuneN <= regWriteData[ccr_pkg::FINE_N_W-1:0];
      if (wrFineR)
      begin
        fineTuneR <= regWriteData[ccr_pkg::FINE_R_LSB +: ccr_pkg::FINE_R_W];
        fineTuneSourceSelect <= regWriteData[ccr_pkg::FINE_SRC_BIT];
      end
      if (wrWatchdog)
      begin
        wdResetEnable <= regWriteData[ccr_pkg::WD_RST_EN_BIT];
        wdRecoverPrevious <= regWriteData[ccr_pkg::WD_SRC_BIT];
        timeoutSel <= wrTimeout;
      end
      if (wrFreqLo)
        frequencyWord[7:0] <= regWriteData;
      if (wrFreqHi)
        frequencyWord[15:8] <= regWriteData;
    end
  end

  assign pllConstant = ccr_pkg::PLL_CONSTANT;

  // strap capture after reset release, once the synchronisers have settled
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      strapMeta <= 5'h00;
      strapStable <= 5'h00;
      strapWait <= 3'h0;
      strapCaptured <= 1'b0;
      strapFreq <= 5'h00;
    end
    else if (clockEnable)
    begin
      strapMeta <= frequencySelectStraps;
      strapStable <= strapMeta;
      if (!strapCaptured)
      begin
        if (strapWait == 3'(ccr_pkg::STRAP_SETTLE_CYCLES - 1))
        begin
          strapCaptured <= 1'b1;
          strapFreq <= strapStable;
        end
        else
          strapWait <= strapWait + 3'h1;
      end
    end
  end

  // watchdog timing on reference clock edges
  logic wdRunning;
  logic wdFirstDone;
  logic [23:0] refCount;
  logic [3:0] secondCount;
  logic [4:0] pulseCount;
  wire refEdge = pinRise[ccr_pkg::PIN_REF];
  wire tickDone = refEdge & (refCount == 24'(REF_CYCLES_PER_TICK - 1));
  wire expire = wdRunning & tickDone & ((secondCount + 4'h1) >= timeoutSel);
  wire [4:0] recoverFreq = wdRecoverPrevious ? prevSwFreq : strapFreq;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wdRunning <= 1'b0;
      wdFirstDone <= 1'b0;
      refCount <= 24'h000000;
      secondCount <= 4'h0;
    end
    else if (clockEnable)
    begin
      if (timeoutZeroWrite)
        wdRunning <= 1'b0;
      else if (armWatchdog)
        wdRunning <= 1'b1;
      if (armWatchdog | expire | !wdRunning)
      begin
        refCount <= 24'h000000;
        secondCount <= 4'h0;
      end
      else if (refEdge)
      begin
        refCount <= tickDone ? 24'h000000 : refCount + 24'h000001;
        if (tickDone)
          secondCount <= secondCount + 4'h1;
      end
      if (armWatchdog)
        wdFirstDone <= 1'b0;
      else if (expire)
        wdFirstDone <= 1'b1;
    end
  end

  // alarm: expiry wins over a clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      watchdogAlarmFlag <= 1'b0;
    else if (clockEnable)
    begin
      if (expire)
        watchdogAlarmFlag <= 1'b1;
      else if (timeoutZeroWrite)
        watchdogAlarmFlag <= 1'b0;
    end
  end

  // frequency selection: applied in the write cycle, timer starts after
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      activeFrequencySelect <= ccr_pkg::SW_FREQ_RESET;
      lastSwFreq <= ccr_pkg::SW_FREQ_RESET;
      prevSwFreq <= ccr_pkg::SW_FREQ_RESET;
    end
    else if (clockEnable)
    begin
      if (wrSwFreq)
      begin
        activeFrequencySelect <= regWriteData[ccr_pkg::FREQ_SEL_W-1:0];
        lastSwFreq <= regWriteData[ccr_pkg::FREQ_SEL_W-1:0];
        prevSwFreq <= lastSwFreq;
      end
      else if (strapCaptured == 1'b0 && strapWait == 3'(ccr_pkg::STRAP_SETTLE_CYCLES - 1))
        activeFrequencySelect <= strapStable;
      else if (expire && wdFirstDone)
        activeFrequencySelect <= recoverFreq;
    end
  end

  // system reset pulse, width counted in reference cycles
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pulseCount <= 5'h00;
      systemResetOutN <= 1'b1;
    end
    else if (clockEnable)
    begin
      if (expire && wdResetEnable)
      begin
        pulseCount <= 5'(ccr_pkg::RESET_PULSE_REF_CYCLES);
        systemResetOutN <= 1'b0;
      end
      else if (pulseCount != 5'h00)
      begin
        if (refEdge)
          pulseCount <= pulseCount - 5'h01;
        systemResetOutN <= 1'b0;
      end
      else
        systemResetOutN <= 1'b1;
    end
  end

  // power-good: first falling edge only
  always_ff @(posedge clock)
  begin
    if (rst)
      powerGoodLatched <= 1'b0;
    else if (clockEnable && pinFall[ccr_pkg::PIN_PWRGD_N])
      powerGoodLatched <= 1'b1;
  end

  // power-down sequencing
  ccr_pkg::ccr_pd_state_t pdState;
  logic [1:0] pdSamples;
  logic [19:0] resumeCount;
  wire diffMode = pinLevel[ccr_pkg::PIN_FAMILY];
  wire pdLow = ~pinLevel[ccr_pkg::PIN_PD_N];
  wire sampleEdge = diffMode ? pinRise[ccr_pkg::PIN_CPU_C] : pinRise[ccr_pkg::PIN_CPU_T];
  wire pdEnter = sampleEdge & pdLow & (pdSamples == 2'(ccr_pkg::PD_SAMPLES - 1));
  wire outFall = pinFall[ccr_pkg::PIN_OUT];
  wire outRise = pinRise[ccr_pkg::PIN_OUT];
  wire resumeLimit = resumeCount == 20'(RESUME_MAX_CYCLES - 1);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pdState <= ccr_pkg::PD_RUN;
      pdSamples <= 2'h0;
      resumeCount <= 20'h00000;
      nonCpuHoldLow <= 1'b0;
      refHoldLow <= 1'b0;
      cpuHoldLow <= 1'b0;
      cpuTrueDriveHigh <= 1'b0;
      cpuCompOeN <= 1'b0;
      pllEnable <= 1'b1;
      oscillatorEnable <= 1'b1;
      serialInterfaceEnable <= 1'b1;
    end
    else if (clockEnable)
    begin
      unique case (pdState)
        ccr_pkg::PD_RUN:
        begin
          if (sampleEdge)
            pdSamples <= pdLow ? 2'(ccr_pkg::PD_SAMPLES - 1) & (pdSamples + 2'h1) : 2'h0;
          if (pdEnter && diffMode)
          begin
            cpuTrueDriveHigh <= 1'b1;
            cpuCompOeN <= 1'b1;
            pdState <= ccr_pkg::PD_HOLDING;
          end
          else if (pdEnter)
          begin
            nonCpuHoldLow <= 1'b1;
            refHoldLow <= 1'b1;
            cpuHoldLow <= 1'b1;
            pllEnable <= 1'b0;
            oscillatorEnable <= 1'b0;
            serialInterfaceEnable <= 1'b0;
            pdState <= ccr_pkg::PD_DOWN;
          end
        end
        ccr_pkg::PD_HOLDING:
        begin
          if (outFall)
            nonCpuHoldLow <= 1'b1;
          if (pinFall[ccr_pkg::PIN_REF])
            refHoldLow <= 1'b1;
          if ((nonCpuHoldLow | outFall) && (refHoldLow | pinFall[ccr_pkg::PIN_REF]))
            pdState <= ccr_pkg::PD_DOWN;
        end
        ccr_pkg::PD_DOWN:
        begin
          pdSamples <= 2'h0;
          resumeCount <= 20'h00000;
          if (!pdLow)
          begin
            pllEnable <= 1'b1;
            oscillatorEnable <= 1'b1;
            pdState <= ccr_pkg::PD_WAKING;
          end
        end
        ccr_pkg::PD_WAKING:
        begin
          resumeCount <= resumeCount + 20'h00001;
          if (outRise || (cpuHoldLow == 1'b0 && resumeLimit))
          begin
            nonCpuHoldLow <= 1'b0;
            refHoldLow <= 1'b0;
            cpuHoldLow <= 1'b0;
            cpuTrueDriveHigh <= 1'b0;
            cpuCompOeN <= 1'b0;
            serialInterfaceEnable <= 1'b1;
            pdState <= ccr_pkg::PD_RUN;
          end
        end
      endcase
    end
  end
endmodule // ccr_clock_control

// file: rtl/ccr_pin_sync.sv
// ccr_pin_sync: two-flop synchronisers with edge detection for a bank of pins.
// assumes pins are asynchronous to clock; the third flop only feeds edge detect.
`timescale 1ns/1ps
module ccr_pin_sync #(
  parameter int N = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic [N-1:0] pinIn,
  output logic [N-1:0] level,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);
  logic [N-1:0] meta;
  logic [N-1:0] stable;
  logic [N-1:0] prev;

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_pin
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          meta[i] <= 1'b0;
          stable[i] <= 1'b0;
          prev[i] <= 1'b0;
        end
        else if (clockEnable)
        begin
          meta[i] <= pinIn[i];
          stable[i] <= meta[i];
          prev[i] <= stable[i];
        end
      end
      assign level[i] = stable[i];
      assign rise[i] = stable[i] & ~prev[i];
      assign fall[i] = ~stable[i] & prev[i];
    end
  endgenerate
endmodule // ccr_pin_sync

// file: rtl/ccr_pkg.sv
// ccr_pkg: shared constants for the clock recovery and power-down control block.
// assumes an 8-bit register port and a 200 MHz core clock.
package ccr_pkg;

  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] REG_SPREAD = 8'h01;
  localparam logic [7:0] REG_SW_FREQ = 8'h04;
  localparam logic [7:0] REG_FINE_N = 8'h07;
  localparam logic [7:0] REG_FINE_R = 8'h09;
  localparam logic [7:0] REG_WATCHDOG = 8'h0C;
  localparam logic [7:0] REG_FREQ_LO = 8'h0D;
  localparam logic [7:0] REG_FREQ_HI = 8'h0E;

  // field positions
  localparam int SPREAD_EN_BIT = 7;
  localparam int SPREAD_MODE_BIT = 6;
  localparam int SPREAD_HI_BIT = 5;
  localparam int SPREAD_LO_BIT = 4;
  localparam int WD_RST_EN_BIT = 7;
  localparam int WD_SRC_BIT = 6;
  localparam int WATCHDOG_ALARM_FLAG_BIT = 4;
  localparam int FINE_SRC_BIT = 0;
  localparam int FINE_R_LSB = 1;

  // field widths
  localparam int WD_TIMEOUT_W = 4;
  localparam int FINE_N_W = 7;
  localparam int FINE_R_W = 6;
  localparam int FREQ_SEL_W = 5;
  localparam int FREQ_WORD_W = 16;
  localparam int PLL_CONST_W = 27;

  // values after reset
  localparam logic [3:0] SPREAD_RESET = 4'h0;
  localparam logic [4:0] SW_FREQ_RESET = 5'h00;
  localparam logic [6:0] FINE_N_RESET = 7'h00;
  localparam logic [5:0] FINE_R_RESET = 6'h00;
  localparam logic FINE_SRC_RESET = 1'b0;
  localparam logic WD_RST_EN_RESET = 1'b1;
  localparam logic WD_SRC_RESET = 1'b0;
  localparam logic [3:0] WD_TIMEOUT_OFF = 4'h0;
  localparam logic [15:0] FREQ_WORD_RESET = 16'h0000;

  // single pll constant, 96016000 decimal
  localparam logic [26:0] PLL_CONSTANT = 27'h5B91680;

  // timing
  localparam longint CLOCK_HZ = 200000000;
  localparam longint REF_CLOCK_HZ = 14318180;
  localparam longint WATCHDOG_TICK_S = 1;
  localparam longint REF_CYCLES_PER_TICK = REF_CLOCK_HZ * WATCHDOG_TICK_S;
  localparam longint RESUME_MAX_MS = 3;
  // longest time, rounded down, kept strictly under the limit
  localparam longint RESUME_MAX_CYCLES = (CLOCK_HZ / 1000) * RESUME_MAX_MS - 1;
  localparam int RESET_PULSE_REF_CYCLES = 16;
  localparam int STRAP_SETTLE_CYCLES = 4;
  localparam int PD_SAMPLES = 2;

  // pin indices into the synchroniser bank
  localparam int PIN_CPU_T = 0;
  localparam int PIN_CPU_C = 1;
  localparam int PIN_OUT = 2;
  localparam int PIN_REF = 3;
  localparam int PIN_PD_N = 4;
  localparam int PIN_PWRGD_N = 5;
  localparam int PIN_FAMILY = 6;
  localparam int PIN_COUNT = 7;

  typedef enum logic [1:0] {PD_RUN, PD_HOLDING, PD_DOWN, PD_WAKING} ccr_pd_state_t;

endpackage

// file: test/ccr_clock_control_asserts.sv
// ccr_clock_control_asserts: port-level properties of the clock control block.
// assumes clockEnable is held high around the block.
`timescale 1ns/1ps
module ccr_clock_control_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire logic [4:0] activeFrequencySelect,
  input wire logic [6:0] fineTuneN,
  input wire logic [5:0] fineTuneR,
  input wire logic fineTuneSourceSelect,
  input wire logic [26:0] pllConstant,
  input wire logic spreadEnable,
  input wire logic spreadMode,
  input wire logic spreadTypeHi,
  input wire logic spreadTypeLo,
  input wire logic systemResetOutN,
  input wire logic nonCpuHoldLow,
  input wire logic refHoldLow,
  input wire logic cpuHoldLow,
  input wire logic cpuTrueDriveHigh,
  input wire logic cpuCompOeN,
  input wire logic pllEnable,
  input wire logic oscillatorEnable,
  input wire logic serialInterfaceEnable,
  input wire logic powerGoodLatched
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  wire logic wrOk = regWrite && serialInterfaceEnable;
  wire logic [6:0] wrLow = regWriteData[6:0];
  wire logic [4:0] wrFreq = regWriteData[4:0];
  wire logic [3:0] wrTop = regWriteData[7:4];

  a_read_refused: assert property (regRead && !serialInterfaceEnable |=> regReadData == 8'h00)
    else $error("read answered while serial interface off");
  a_pll_fixed: assert property (pllConstant == 27'h5B91680)
    else $error("pll constant wrong");
  a_spread_field: assert property (wrOk && regAddr == 8'h01 |=>
    {spreadEnable, spreadMode, spreadTypeHi, spreadTypeLo} == $past(wrTop))
    else $error("spread outputs do not follow write");
  a_fine_n: assert property (wrOk && regAddr == 8'h07 |=> fineTuneN == $past(wrLow))
    else $error("fine N does not follow write");
  a_fine_r_mux: assert property (wrOk && regAddr == 8'h09 |=>
    {fineTuneR, fineTuneSourceSelect} == $past(wrLow))
    else $error("fine R or source does not follow write");
  a_freq_switch: assert property (wrOk && regAddr == 8'h04 |=>
    activeFrequencySelect == $past(wrFreq))
    else $error("frequency not switched on request");
  a_pulse_hold: assert property ($fell(systemResetOutN) |=> (!systemResetOutN) [*8])
    else $error("reset pulse too short");
  a_od_shutdown: assert property (!pllEnable |-> !oscillatorEnable && !serialInterfaceEnable
    && cpuHoldLow && nonCpuHoldLow && refHoldLow)
    else $error("shutdown incomplete");
  a_cpu_pin_park: assert property (cpuTrueDriveHigh |-> cpuCompOeN)
    else $error("complement pin driven in power-down");
  a_good_sticky: assert property ($past(powerGoodLatched) |-> powerGoodLatched)
    else $error("power good latch dropped");

  c_reset_pulse: cover property ($fell(systemResetOutN));
  c_od_down: cover property ($fell(pllEnable));
  c_diff_down: cover property ($rose(cpuTrueDriveHigh));
endmodule // ccr_clock_control_asserts

bind ccr_clock_control ccr_clock_control_asserts chk (
  .clock, .rst, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData,
  .activeFrequencySelect, .fineTuneN, .fineTuneR, .fineTuneSourceSelect, .pllConstant,
  .spreadEnable, .spreadMode, .spreadTypeHi, .spreadTypeLo, .systemResetOutN,
  .nonCpuHoldLow, .refHoldLow, .cpuHoldLow, .cpuTrueDriveHigh, .cpuCompOeN, .pllEnable,
  .oscillatorEnable, .serialInterfaceEnable, .powerGoodLatched
);

// file: test/ccr_pin_source.sv
// ccr_pin_source: free-running clock pins seen by the clock control block.
// assumes one link period for every pin, phases unrelated to the core clock.
`timescale 1ns/1ps
module ccr_pin_source #(
  parameter real HALF_NS = 80.0
) (
  output logic cpuClockTrue,
  output logic cpuClockComp,
  output logic outputClockSample,
  output logic refClockSample
);
  initial cpuClockTrue = 1'b0;
  initial outputClockSample = 1'b0;
  initial refClockSample = 1'b0;
  assign cpuClockComp = ~cpuClockTrue;
  initial
  begin
    #3.1;
    forever #(HALF_NS) cpuClockTrue = ~cpuClockTrue;
  end
  initial
  begin
    #21.3;
    forever #(HALF_NS) outputClockSample = ~outputClockSample;
  end
  initial
  begin
    #47.9;
    forever #(HALF_NS) refClockSample = ~refClockSample;
  end
endmodule // ccr_pin_source

// file: test/tb_top.sv
// tb_top: register, watchdog and power-down tests of the clock control block.
// assumes the pin source model drives the clock pins at a 160 ns period.
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWriteData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [4:0] frequencySelectStraps = 5'h0A;
  logic hostFamilySelect = 1'b1;
  logic powerDownN = 1'b1;
  logic terminationPowerGoodN = 1'b1;
  logic [7:0] regReadData;
  logic [4:0] activeFrequencySelect;
  logic [15:0] frequencyWord;
  logic [6:0] fineTuneN;
  logic [5:0] fineTuneR;
  logic [26:0] pllConstant;
  logic systemResetOutN, fineTuneSourceSelect, spreadEnable, spreadMode, spreadTypeHi;
  logic spreadTypeLo, nonCpuHoldLow, refHoldLow, cpuHoldLow, cpuTrueDriveHigh, cpuCompOeN;
  logic pllEnable, oscillatorEnable, serialInterfaceEnable, powerGoodLatched;
  logic cpuClockTrue, cpuClockComp, outputClockSample, refClockSample;
  int errorCnt = 0;
  int nTests = 0;
  int cycles = 0;

  always #2.5 clock = ~clock;

  ccr_pin_source pins (.cpuClockTrue, .cpuClockComp, .outputClockSample, .refClockSample);

  ccr_clock_control #(.REF_CYCLES_PER_TICK(20), .RESUME_MAX_CYCLES(50)) dut (
    .clock, .rst, .clockEnable(1'b1), .regAddr, .regWriteData, .regWrite, .regRead,
    .regReadData, .frequencySelectStraps, .hostFamilySelect, .cpuClockTrue, .cpuClockComp,
    .outputClockSample, .refClockSample, .powerDownN, .terminationPowerGoodN,
    .systemResetOutN, .activeFrequencySelect, .frequencyWord, .fineTuneN, .fineTuneR,
    .fineTuneSourceSelect, .pllConstant, .spreadEnable, .spreadMode, .spreadTypeHi,
    .spreadTypeLo, .nonCpuHoldLow, .refHoldLow, .cpuHoldLow, .cpuTrueDriveHigh, .cpuCompOeN,
    .pllEnable, .oscillatorEnable, .serialInterfaceEnable, .powerGoodLatched
  );

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ends at the falling edge after the write has landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    chk($sformatf("reg %h", a), regReadData, exp);
  endtask

  task automatic report_and_stop;
    $display("Checks %0d errors %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      errorCnt++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk("straps", activeFrequencySelect, 5'h0A);
    chk("pllConstant", pllConstant, 27'h5B91680);
    chk("powerGood", powerGoodLatched, 1'b0);
    rd(8'h0C, 8'h80);
    rd(8'h3F, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h01, {i[0], i[2:0], 4'h0});
      chk("spread", {spreadEnable, spreadMode, spreadTypeHi, spreadTypeLo}, {i[0], i[2:0]});
      rd(8'h01, {i[0], i[2:0], 4'h0});
    end
    wr(8'h07, 8'h5A);
    wr(8'h09, 8'h6B);
    chk("fineTuneN", fineTuneN, 7'h5A);
    chk("fineTuneR", fineTuneR, 6'h35);
    chk("fineSource", fineTuneSourceSelect, 1'b1);
    rd(8'h09, 8'h6B);
    wr(8'h09, 8'h6A);
    chk("fineSource", fineTuneSourceSelect, 1'b0);
    wr(8'h0D, 8'h34);
    wr(8'h0E, 8'h12);
    chk("frequencyWord", frequencyWord, 16'h1234);
    wr(8'h04, 8'h02);
    chk("swFreq", activeFrequencySelect, 5'h02);
    repeat (1500) if (systemResetOutN === 1'b1) @(posedge clock);
    chk("resetOut", systemResetOutN, 1'b1);
    // two seconds armed, cleared before the first expiry
    wr(8'h0C, 8'h82);
    wr(8'h04, 8'h05);
    chk("swFreq", activeFrequencySelect, 5'h05);
    repeat (900) @(posedge clock);
    chk("resetOut", systemResetOutN, 1'b1);
    wr(8'h0C, 8'h80);
    repeat (1500) if (systemResetOutN === 1'b1) @(posedge clock);
    chk("resetOut", systemResetOutN, 1'b1);
    chk("swFreq", activeFrequencySelect, 5'h05);
    // one second armed, left to expire three times
    wr(8'h0C, 8'h81);
    wr(8'h04, 8'h03);
    repeat (1000) if (systemResetOutN !== 1'b0) @(posedge clock);
    @(negedge clock);
    chk("resetOut", systemResetOutN, 1'b0);
    chk("swFreq", activeFrequencySelect, 5'h03);
    rd(8'h0C, 8'h91);
    for (int k = 0; k < 2; k++)
    begin
      repeat (1000) if (systemResetOutN !== 1'b1) @(posedge clock);
      repeat (1000) if (systemResetOutN !== 1'b0) @(posedge clock);
      @(negedge clock);
      chk("resetOut", systemResetOutN, 1'b0);
      chk("swFreq", activeFrequencySelect, 5'h0A);
    end
    repeat (1000) if (systemResetOutN !== 1'b1) @(posedge clock);
    wr(8'h0C, 8'h80);
    rd(8'h0C, 8'h80);
    repeat (1500) if (systemResetOutN === 1'b1) @(posedge clock);
    chk("resetOut", systemResetOutN, 1'b1);
    // recovery to the second-to-last software frequency
    wr(8'h0C, 8'hC1);
    wr(8'h04, 8'h06);
    for (int k = 0; k < 2; k++)
    begin
      repeat (1000) if (systemResetOutN !== 1'b1) @(posedge clock);
      repeat (1000) if (systemResetOutN !== 1'b0) @(posedge clock);
    end
    @(negedge clock);
    chk("swFreqPrev", activeFrequencySelect, 5'h03);
    wr(8'h0C, 8'h80);
    repeat (1000) if (systemResetOutN !== 1'b1) @(posedge clock);
    // differential host power-down
    @(posedge clock);
    powerDownN <= 1'b0;
    repeat (300) if (cpuTrueDriveHigh !== 1'b1) @(posedge clock);
    @(negedge clock);
    chk("cpuTrueDrive", cpuTrueDriveHigh, 1'b1);
    chk("cpuCompOeN", cpuCompOeN, 1'b1);
    repeat (100) if (refHoldLow !== 1'b1) @(posedge clock);
    repeat (100) if (nonCpuHoldLow !== 1'b1) @(posedge clock);
    @(negedge clock);
    chk("refHold", refHoldLow, 1'b1);
    chk("nonCpuHold", nonCpuHoldLow, 1'b1);
    @(posedge clock);
    powerDownN <= 1'b1;
    repeat (70) if (nonCpuHoldLow !== 1'b0) @(posedge clock);
    @(negedge clock);
    chk("nonCpuHold", nonCpuHoldLow, 1'b0);
    // open-drain host shutdown
    @(posedge clock);
    hostFamilySelect <= 1'b0;
    repeat (10) @(posedge clock);
    powerDownN <= 1'b0;
    repeat (300) if (pllEnable !== 1'b0) @(posedge clock);
    @(negedge clock);
    chk("pllEnable", pllEnable, 1'b0);
    chk("oscEnable", oscillatorEnable, 1'b0);
    chk("serialEnable", serialInterfaceEnable, 1'b0);
    chk("cpuHold", cpuHoldLow, 1'b1);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h00);
    @(posedge clock);
    powerDownN <= 1'b1;
    repeat (300) if (nonCpuHoldLow !== 1'b0) @(posedge clock);
    @(negedge clock);
    chk("pllEnable", pllEnable, 1'b1);
    chk("nonCpuHold", nonCpuHoldLow, 1'b0);
    rd(8'h01, 8'hF0);
    // only the first power-good fall counts
    @(posedge clock);
    terminationPowerGoodN <= 1'b0;
    repeat (10) @(posedge clock);
    terminationPowerGoodN <= 1'b1;
    repeat (10) @(posedge clock);
    @(negedge clock);
    chk("powerGood", powerGoodLatched, 1'b1);
    report_and_stop();
  end
endmodule // tb_top
